// *** bench/rtcrd_chk.sv ***
// Purpose: wire checks on the link between the two ends
// Assumes: QTR_CYC of 8, a quarter lasts 8 clocks
// Notes: sees only interface signals
module rtcrd_chk (
    // clock and reset
    input logic clk_sys,
    input logic rst_n,
    // link
    input logic dev_sda_en_n,
    input logic scl,
    input logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // start and stop: sda edge while scl stays high
    sequence start_s;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence stop_s;
        scl && $past(scl) && $rose(sda);
    endsequence
    a_rst_free: assert property ($rose(rst_n) |-> dev_sda_en_n)
        else $error("device drives at reset");
    a_start_hear: assert property (start_s |-> dev_sda_en_n[*8])
        else $error("device drives at start");
    a_stop_rest: assert property (stop_s |=> dev_sda_en_n[*8])
        else $error("device drives after stop");
    a_sda_low_scl: assert property ($changed(dev_sda_en_n) |-> !scl)
        else $error("device sda moved with scl high");
    a_drive_lag: assert property (
        $fell(dev_sda_en_n) |-> !$past(scl, 3))
        else $error("device drove too soon after scl fall");
    a_bit_hold: assert property (
        $rose(scl) |-> $stable(dev_sda_en_n)[*8])
        else $error("device bit not held with scl high");
    a_scl_high: assert property ($rose(scl) |-> scl[*8])
        else $error("scl high too short");
    a_scl_low: assert property ($fell(scl) |-> (!scl)[*6])
        else $error("scl low too short");
endmodule

// *** bench/testbench.sv ***
// Purpose: runs read transfers through both ends of the link
// Assumes: QTR_CYC of 8 keeps bit slots short
// Notes: device memory preloaded with a known pattern
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import rtcrd_pkg::*;
    logic clk_sys = 0, rst_n = 0, cmd_valid = 0, rd_ready = 1, ld_en = 0;
    logic cmd_ready, rd_valid, m_busy, nack, d_busy, nack_seen = 0;
    rtcrd_op_e cmd_op = RTCRD_OP_CUR;
    rtcrd_sel_e cmd_sel = RTCRD_SEL_ARR, ld_sel = RTCRD_SEL_ARR;
    logic [15:0] cmd_addr = '0, ld_addr = '0, addr_count;
    logic [7:0] cmd_len = '0, ld_data = '0, rd_data;
    int bad_count = 0, compares = 0, cyc = 0;
    // both ends joined by the link, checker beside it
    rtcrd_if link_if ();
    rtcrd_mst #(.QTR_CYC(8)) u_rtcrd_mst (.clk_sys, .rst_n, .link(link_if),
        .cmd_valid, .cmd_ready, .cmd_op, .cmd_sel, .cmd_addr, .cmd_len,
        .rd_valid, .rd_ready, .rd_data, .busy(m_busy), .nack);
    rtcrd_dev u_rtcrd_dev (.clk_sys, .rst_n, .link(link_if), .ld_en,
        .ld_sel, .ld_addr, .ld_data, .addr_count, .busy(d_busy));
    rtcrd_chk u_rtcrd_chk (.clk_sys, .rst_n,
        .dev_sda_en_n(link_if.dev_sda_en_n), .scl(link_if.scl),
        .sda(link_if.sda));
    // bench clock
    always #50 clk_sys = !clk_sys;
    // cycle ceiling and nack watch
    always @(negedge clk_sys)
    begin
        cyc++;
        if (nack === 1'b1)
            nack_seen = 1;
        if (cyc == 40000)
        begin
            bad_count++;
            results();
        end
    end
    // expected memory contents
    function automatic logic [7:0] pat(rtcrd_sel_e s, logic [15:0] a);
        return a[7:0] ^ (s == RTCRD_SEL_CCR ? 8'ha5 : {8{a[8]}});
    endfunction
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic idle();
        do @(negedge clk_sys); while (m_busy === 1'b1);
    endtask
    task automatic go(rtcrd_op_e op, rtcrd_sel_e s, logic [15:0] a,
        logic [7:0] len);
        @(posedge clk_sys);
        #1;
        cmd_op = op;
        cmd_sel = s;
        cmd_addr = a;
        cmd_len = len;
        cmd_valid = 1;
        @(posedge clk_sys);
        #1 cmd_valid = 0;
    endtask
    // take n bytes, then check where the counter stands
    task automatic pop(rtcrd_sel_e s, logic [15:0] a, int n,
        logic [15:0] top);
        for (int i = 0; i < n; i++)
        begin
            do @(negedge clk_sys); while (rd_valid !== 1'b1);
            chk("rd_data", {8'h00, pat(s, a)}, {8'h00, rd_data});
            a = (a + 16'h0001) & top;
        end
        idle();
        chk("addr_count", a, addr_count);
    endtask
    task automatic t_load();
        for (int i = 0; i < 576; i++)
        begin
            @(posedge clk_sys);
            #1 ld_en = 1;
            ld_sel = i < 512 ? RTCRD_SEL_ARR : RTCRD_SEL_CCR;
            ld_addr = i[15:0] & 16'h01ff;
            ld_data = pat(ld_sel, ld_addr);
        end
        @(posedge clk_sys);
        #1 ld_en = 0;
    endtask
    task automatic t_seta();
        go(RTCRD_OP_SETA, RTCRD_SEL_ARR, 16'h01fe, 8'h00);
        idle();
        chk("addr_count", 16'h01fe, addr_count);
        chk("dev_busy", 16'h0000, {15'h0000, d_busy});
        go(RTCRD_OP_CUR, RTCRD_SEL_ARR, 16'h0000, 8'h04);
        pop(RTCRD_SEL_ARR, 16'h01fe, 4, 16'h01ff);
    endtask
    // buffer fills and stalls the link, then drains
    task automatic t_fill();
        @(posedge clk_sys);
        #1 rd_ready = 0;
        go(RTCRD_OP_RAND, RTCRD_SEL_ARR, 16'h00f8, 8'h28);
        repeat (14000) @(negedge clk_sys);
        chk("mst_busy", 16'h0001, {15'h0000, m_busy});
        chk("cmd_ready", 16'h0000, {15'h0000, cmd_ready});
        @(posedge clk_sys);
        #1 rd_ready = 1;
        pop(RTCRD_SEL_ARR, 16'h00f8, 40, 16'h01ff);
        chk("nack", 16'h0000, {15'h0000, nack_seen});
    endtask
    // main sequence
    initial
    begin
        repeat (2) @(posedge clk_sys);
        #1 rst_n = 1;
        chk("addr_count", 16'h0000, addr_count);
        t_load();
        go(RTCRD_OP_CUR, RTCRD_SEL_ARR, 16'h0000, 8'h00);
        pop(RTCRD_SEL_ARR, 16'h0000, 1, 16'h01ff);
        go(RTCRD_OP_RAND, RTCRD_SEL_CCR, 16'h003e, 8'h03);
        pop(RTCRD_SEL_CCR, 16'h003e, 3, 16'h003f);
        t_seta();
        t_fill();
        results();
    end
endmodule

// *** include/rtcrd_defines.svh ***
// Purpose: named constants shared by both ends of the read path link
// Assumes: included by its bare name
// Notes: times in ns; cycle counts derived from them
`ifndef RTCRD_DEFINES_SVH
`define RTCRD_DEFINES_SVH
// slave address patterns (upper seven bits)
`define RTCRD_ID_ARR 7'h57
`define RTCRD_ID_CCR 7'h6f
// direction bit values
`define RTCRD_RW_READ 1'b1
`define RTCRD_RW_WRITE 1'b0
// address counter
`define RTCRD_ADDR_RST 16'h0000
`define RTCRD_ADDR_STEP 16'h0001
`define RTCRD_AHI 15:8
`define RTCRD_ALO 7:0
// byte framing
`define RTCRD_MSB 7
`define RTCRD_BIT_RST 4'h0
`define RTCRD_LAST_BIT 4'h7
`define RTCRD_ACK_BIT 4'h8
`define RTCRD_BIT_STEP 4'h1
// quarter phases of one scl bit slot
`define RTCRD_PH_SET 2'h0
`define RTCRD_PH_RISE 2'h1
`define RTCRD_PH_SAMPLE 2'h2
`define RTCRD_PH_LAST 2'h3
`define RTCRD_PH_STEP 2'h1
// idle level of both pins after reset
`define RTCRD_PINS_IDLE 2'h3
// timing
`define RTCRD_CLK_PERIOD_NS 100
`define RTCRD_SCL_PERIOD_NS 10000
`define RTCRD_QTR_CYC (`RTCRD_SCL_PERIOD_NS / (4 * `RTCRD_CLK_PERIOD_NS))
// buffering and memory sizes
`define RTCRD_FIFO_DEPTH 32
`define RTCRD_ARR_AW 9
`define RTCRD_CCR_AW 6
`endif

// *** include/rtcrd_if.sv ***
// Purpose: two-wire link between master end and device end
// Assumes: open-drain wires with pull-up
// Notes: an enable low means that party pulls the wire to its value
interface rtcrd_if;
    logic mst_scl_val;
    logic mst_scl_en_n;
    logic mst_sda_val;
    logic mst_sda_en_n;
    logic dev_sda_val;
    logic dev_sda_en_n;
    logic scl;
    logic sda;
    // wired-and with pull-up
    assign scl = !(!mst_scl_en_n && !mst_scl_val);
    assign sda = !((!mst_sda_en_n && !mst_sda_val) ||
        (!dev_sda_en_n && !dev_sda_val));
    modport mst (output mst_scl_val, mst_scl_en_n, mst_sda_val,
        mst_sda_en_n, input scl, sda);
    modport dev (output dev_sda_val, dev_sda_en_n, input scl, sda);
endinterface

// *** include/rtcrd_pkg.sv ***
// Purpose: types shared by both ends
// Assumes: nothing
// Notes: states and modes only, numbers live in the defines header
package rtcrd_pkg;
    // which memory space a slave address selects
    typedef enum logic {RTCRD_SEL_ARR, RTCRD_SEL_CCR} rtcrd_sel_e;
    // master transfer kinds
    typedef enum logic [1:0] {RTCRD_OP_CUR, RTCRD_OP_RAND, RTCRD_OP_SETA}
        rtcrd_op_e;
    // device end states
    typedef enum logic [2:0] {D_IDLE, D_DEV, D_RXA, D_ACK, D_TX, D_TACK}
        rtcrd_dst_e;
    // master end states
    typedef enum logic [3:0] {M_IDLE, M_ST1, M_DEVW, M_AHI, M_ALO, M_ST2,
        M_DEVR, M_RD, M_STOP} rtcrd_mst_e;
endpackage

// *** verilog/rtcrd_dev.sv ***
// Purpose: device end of the read path, serves reads from two spaces
// Assumes: master changes sda only while scl is low, except start/stop
// Notes: contents are preloaded through the user load port
`include "rtcrd_defines.svh"
module rtcrd_dev #(
    parameter int ARR_AW = `RTCRD_ARR_AW,
    parameter int CCR_AW = `RTCRD_CCR_AW
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // link
    rtcrd_if.dev link,
    // contents load port
    input wire logic ld_en,
    input wire rtcrd_pkg::rtcrd_sel_e ld_sel,
    input wire logic [15:0] ld_addr,
    input wire logic [7:0] ld_data,
    // status
    output logic [15:0] addr_count,
    output logic busy
);
    import rtcrd_pkg::*;
    localparam int ARR_DEPTH = 1 << ARR_AW;
    localparam int CCR_DEPTH = 1 << CCR_AW;
    localparam logic [15:0] ARR_LAST = 16'(ARR_DEPTH - 1);
    localparam logic [15:0] CCR_LAST = 16'(CCR_DEPTH - 1);

    logic [7:0] mem_arr [0:ARR_DEPTH-1];
    logic [7:0] mem_ccr [0:CCR_DEPTH-1];
    logic [1:0] sy1;
    logic [1:0] sy2;
    logic [1:0] sy3;
    logic scl_f;
    logic sda_f;
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    rtcrd_dst_e st;
    rtcrd_dst_e ack_next;
    rtcrd_sel_e sel;
    logic a_lo;
    logic [3:0] bitc;
    logic [7:0] shreg;
    logic [7:0] addr_hi;
    logic [15:0] addr;
    logic [7:0] rd_now;
    logic sda_en_n;
    logic rx_state;
    logic rx_bit;
    logic rx_done;
    logic load_now;

    // true when the upper seven bits name one of our two spaces
    function automatic logic id_hit(input logic [6:0] id);
        return (id == `RTCRD_ID_ARR) || (id == `RTCRD_ID_CCR);
    endfunction

    // next counter value, wrapping at the end of the selected space
    function automatic logic [15:0] inc_addr(input logic [15:0] a,
        input rtcrd_sel_e s);
        logic [15:0] last;
        last = (s == RTCRD_SEL_CCR) ? CCR_LAST : ARR_LAST;
        return (a >= last) ? `RTCRD_ADDR_RST : a + `RTCRD_ADDR_STEP;
    endfunction

    // byte at a counter value in the selected space
    function automatic logic [7:0] rd_byte(input logic [15:0] a,
        input rtcrd_sel_e s);
        return (s == RTCRD_SEL_CCR) ? mem_ccr[a[CCR_AW-1:0]] :
            mem_arr[a[ARR_AW-1:0]];
    endfunction

    // pins: three flops, a change counts when the last two agree
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sy1 <= `RTCRD_PINS_IDLE;
            sy2 <= `RTCRD_PINS_IDLE;
            sy3 <= `RTCRD_PINS_IDLE;
        end
        else
        begin
            sy1 <= {link.scl, link.sda};
            sy2 <= sy1;
            sy3 <= sy2;
        end
    end

    // filtered levels and their previous values for edge finding
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            if (sy2[1] == sy3[1])
                scl_f <= sy3[1];
            if (sy2[0] == sy3[0])
                sda_f <= sy3[0];
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    // bus events
    assign scl_rise = scl_f && !scl_q;
    assign scl_fall = !scl_f && scl_q;
    assign start_c = scl_f && scl_q && sda_q && !sda_f;
    assign stop_c = scl_f && scl_q && !sda_q && sda_f;

    // byte receive and transmit strobes
    assign rx_state = (st == D_DEV) || (st == D_RXA);
    assign rx_bit = scl_rise && rx_state && (bitc != `RTCRD_ACK_BIT);
    assign rx_done = scl_fall && rx_state && (bitc == `RTCRD_ACK_BIT);
    assign load_now = !start_c && !stop_c && scl_fall &&
        ((st == D_ACK && ack_next == D_TX) || st == D_TACK);

    // byte at the counter; a process also wakes on memory loads
    always_comb
    begin
        rd_now = rd_byte(addr, sel);
    end

    // outputs
    assign link.dev_sda_val = 1'b0;
    assign link.dev_sda_en_n = sda_en_n;
    assign addr_count = addr;
    assign busy = (st != D_IDLE);

    // contents load from the user side
    always_ff @(posedge clk_sys)
    begin
        if (ld_en && ld_sel == RTCRD_SEL_ARR)
            mem_arr[ld_addr[ARR_AW-1:0]] <= ld_data;
        if (ld_en && ld_sel == RTCRD_SEL_CCR)
            mem_ccr[ld_addr[CCR_AW-1:0]] <= ld_data;
    end

    // protocol sequence; start and stop override every state
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= D_IDLE;
            ack_next <= D_IDLE;
            sel <= RTCRD_SEL_ARR;
            a_lo <= 1'b0;
            bitc <= `RTCRD_BIT_RST;
        end
        else if (start_c)
        begin
            st <= D_DEV;
            bitc <= `RTCRD_BIT_RST;
        end
        else if (stop_c)
            st <= D_IDLE;
        else
        begin
            unique case (st)
                D_IDLE: ; // standby, bus ignored
                D_DEV:
                    if (rx_bit)
                        bitc <= bitc + `RTCRD_BIT_STEP;
                    else if (rx_done && id_hit(shreg[`RTCRD_MSB:1]))
                    begin
                        st <= D_ACK;
                        sel <= (shreg[`RTCRD_MSB:1] == `RTCRD_ID_CCR) ?
                            RTCRD_SEL_CCR : RTCRD_SEL_ARR;
                        // read goes to data, write to the address bytes
                        ack_next <= (shreg[0] == `RTCRD_RW_READ) ? D_TX :
                            D_RXA;
                        a_lo <= 1'b0;
                    end
                    else if (rx_done)
                        st <= D_IDLE;
                D_RXA:
                    if (rx_bit)
                        bitc <= bitc + `RTCRD_BIT_STEP;
                    else if (rx_done)
                    begin
                        st <= D_ACK;
                        // after the low byte only start or stop matter
                        ack_next <= a_lo ? D_IDLE : D_RXA;
                        a_lo <= !a_lo;
                    end
                D_ACK:
                    if (scl_fall)
                    begin
                        st <= ack_next;
                        bitc <= `RTCRD_BIT_RST;
                    end
                D_TX:
                    if (scl_fall && bitc == `RTCRD_LAST_BIT)
                        st <= D_TACK;
                    else if (scl_fall)
                        bitc <= bitc + `RTCRD_BIT_STEP;
                D_TACK:
                    if (scl_rise && sda_f)
                        st <= D_IDLE; // no ack: wait for stop
                    else if (scl_fall)
                    begin
                        st <= D_TX;
                        bitc <= `RTCRD_BIT_RST;
                    end
            endcase
        end
    end

    // shift register: receive bits, then load and shift out data
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            shreg <= 8'h00;
        else if (rx_bit)
            shreg <= {shreg[`RTCRD_MSB-1:0], sda_f};
        else if (load_now)
            shreg <= rd_now;
        else if (st == D_TX && scl_fall)
            shreg <= {shreg[`RTCRD_MSB-1:0], 1'b0};
    end

    // address counter: loaded by word address, stepped per byte sent
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr <= `RTCRD_ADDR_RST;
            addr_hi <= 8'h00;
        end
        else if (st == D_RXA && rx_done && !a_lo)
            addr_hi <= shreg;
        else if (st == D_RXA && rx_done)
            addr <= {addr_hi, shreg};
        else if (load_now)
            // runs through pages, wraps at the end
            addr <= inc_addr(addr, sel);
    end

    // sda drive: ack, data bits, release for the master's ack
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            sda_en_n <= 1'b1;
        else if (start_c || stop_c)
            sda_en_n <= 1'b1;
        else if (rx_done && (st == D_RXA || id_hit(shreg[`RTCRD_MSB:1])))
            sda_en_n <= 1'b0;
        else if (load_now)
            sda_en_n <= rd_now[`RTCRD_MSB];
        else if (st == D_ACK && scl_fall)
            sda_en_n <= 1'b1;
        else if (st == D_TX && scl_fall)
            sda_en_n <= (bitc == `RTCRD_LAST_BIT) ? 1'b1 :
                shreg[`RTCRD_MSB-1];
    end
endmodule

// *** verilog/rtcrd_fifo.sv ***
// Purpose: read data buffer between link and user
// Assumes: DEPTH is a power of two
// Notes: full and empty from pointers with one wrap bit
`include "rtcrd_defines.svh"
module rtcrd_fifo #(
    parameter int W = 8,
    parameter int DEPTH = `RTCRD_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [0:DEPTH-1];
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic full;
    logic empty;

    // status from pointer comparison
    assign empty = (wp == rp);
    assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rp[AW-1:0]];

    // storage
    always_ff @(posedge clk_sys)
    begin
        if (in_valid && !full)
            mem[wp[AW-1:0]] <= in_data;
    end

    // pointers
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp <= '0;
            rp <= '0;
        end
        else
        begin
            if (in_valid && !full)
                wp <= wp + (AW+1)'(1);
            if (out_ready && !empty)
                rp <= rp + (AW+1)'(1);
        end
    end
endmodule

// *** verilog/rtcrd_mst.sv ***
// Purpose: bus master end, issues reads and address loads
// Assumes: device never stretches scl
// Notes: scl made by divider; read data stalls on a full buffer
`include "rtcrd_defines.svh"
module rtcrd_mst #(
    parameter int QTR_CYC = `RTCRD_QTR_CYC,
    parameter int FIFO_DEPTH = `RTCRD_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // link
    rtcrd_if.mst link,
    // command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire rtcrd_pkg::rtcrd_op_e cmd_op,
    input wire rtcrd_pkg::rtcrd_sel_e cmd_sel,
    input wire logic [15:0] cmd_addr,
    input wire logic [7:0] cmd_len,
    // read data
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] rd_data,
    // status
    output logic busy,
    output logic nack
);
    import rtcrd_pkg::*;
    localparam int QW = $clog2(QTR_CYC + 1);
    rtcrd_mst_e st;
    rtcrd_op_e op;
    rtcrd_sel_e sel;
    logic [15:0] addr;
    logic [7:0] left;
    logic [7:0] txb;
    logic [7:0] rxb;
    logic [3:0] bitn;
    logic [1:0] ph;
    logic [QW-1:0] qcnt;
    logic [2:0] sy;
    logic sda_f;
    logic scl_l;
    logic sda_l;
    logic next_scl;
    logic next_sda;
    logic ackok;
    logic tick;
    logic stall;
    logic slot_end;
    logic is_wr;
    logic smp;
    logic f_in_valid;
    logic f_in_ready;

    // address byte from selected space and direction
    function automatic logic [7:0] id_byte(input rtcrd_sel_e s,
        input logic rw);
        return {(s == RTCRD_SEL_CCR) ? `RTCRD_ID_CCR : `RTCRD_ID_ARR, rw};
    endfunction

    assign tick = (qcnt == QW'(QTR_CYC - 1));
    assign is_wr = (st == M_DEVW) || (st == M_AHI) || (st == M_ALO) ||
        (st == M_DEVR);
    // hold scl low before a byte while the buffer has no room
    assign stall = (st == M_RD) && (bitn == `RTCRD_BIT_RST) &&
        (ph == `RTCRD_PH_SET) && !f_in_ready;
    assign slot_end = tick && (ph == `RTCRD_PH_LAST);
    assign smp = tick && (ph == `RTCRD_PH_SAMPLE);
    assign f_in_valid = smp && (st == M_RD) && (bitn == `RTCRD_LAST_BIT);
    assign cmd_ready = (st == M_IDLE);
    assign busy = (st != M_IDLE);
    assign link.mst_scl_val = 1'b0;
    assign link.mst_sda_val = 1'b0;
    assign link.mst_scl_en_n = scl_l;
    assign link.mst_sda_en_n = sda_l;

    // sda pin: three flops, accept when last two agree
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sy <= 3'h7;
            sda_f <= 1'b1;
        end
        else
        begin
            sy <= {sy[1:0], link.sda};
            if (sy[1] == sy[2])
                sda_f <= sy[2];
        end
    end

    // quarter-bit divider, held at zero while idle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            qcnt <= '0;
        else if (tick || st == M_IDLE)
            qcnt <= '0; // first scl low after idle lasts a full quarter
        else
            qcnt <= qcnt + QW'(1);
    end

    // wire levels per slot kind and quarter
    always_comb
    begin
        next_scl = 1'b1;
        next_sda = 1'b1;
        unique case (st)
            M_IDLE: ;
            M_ST1, M_ST2:
            begin
                next_scl = (ph == `RTCRD_PH_RISE) || (ph == `RTCRD_PH_SAMPLE);
                next_sda = (ph == `RTCRD_PH_SET) || (ph == `RTCRD_PH_RISE);
            end
            M_STOP:
            begin
                next_scl = (ph != `RTCRD_PH_SET);
                next_sda = (ph == `RTCRD_PH_SAMPLE) || (ph == `RTCRD_PH_LAST);
            end
            M_DEVW, M_AHI, M_ALO, M_DEVR:
            begin
                next_scl = (ph == `RTCRD_PH_RISE) || (ph == `RTCRD_PH_SAMPLE);
                next_sda = txb[`RTCRD_MSB];
            end
            M_RD:
            begin
                next_scl = (ph == `RTCRD_PH_RISE) || (ph == `RTCRD_PH_SAMPLE);
                // ack all but the last byte, nack that one
                next_sda = (bitn == `RTCRD_ACK_BIT) ? (left == 8'h01) : 1'b1;
            end
        endcase
    end

    // registered pin drive
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_l <= 1'b1;
            sda_l <= 1'b1;
        end
        else
        begin
            scl_l <= next_scl;
            sda_l <= next_sda;
        end
    end

    // transfer sequence
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            st <= M_IDLE;
        else
        begin
            unique case (st)
                M_IDLE: if (cmd_valid) st <= M_ST1;
                M_ST1:
                    if (slot_end)
                        st <= (op == RTCRD_OP_CUR) ? M_DEVR : M_DEVW;
                M_DEVW, M_AHI, M_ALO, M_DEVR:
                    if (slot_end && bitn == `RTCRD_ACK_BIT)
                    begin
                        if (!ackok)
                            st <= M_STOP;
                        else if (st == M_DEVW)
                            st <= M_AHI;
                        else if (st == M_AHI)
                            st <= M_ALO;
                        else if (st == M_ALO)
                            // stop loads the address, start reads it
                            st <= (op == RTCRD_OP_SETA) ? M_STOP : M_ST2;
                        else
                            st <= M_RD;
                    end
                M_ST2: if (slot_end) st <= M_DEVR;
                M_RD:
                    if (slot_end && bitn == `RTCRD_ACK_BIT && left == 8'h01)
                        st <= M_STOP;
                M_STOP: if (slot_end) st <= M_IDLE;
            endcase
        end
    end

    // command latch and remaining byte count
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op <= RTCRD_OP_CUR;
            sel <= RTCRD_SEL_ARR;
            addr <= `RTCRD_ADDR_RST;
            left <= 8'h01;
        end
        else if (st == M_IDLE && cmd_valid)
        begin
            op <= cmd_op;
            sel <= cmd_sel;
            addr <= cmd_addr;
            left <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
        end
        else if (st == M_RD && slot_end && bitn == `RTCRD_ACK_BIT)
            left <= left - 8'h01;
    end

    // quarter and bit counters
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ph <= `RTCRD_PH_SET;
            bitn <= `RTCRD_BIT_RST;
        end
        else if (st == M_IDLE)
        begin
            ph <= `RTCRD_PH_SET;
            bitn <= `RTCRD_BIT_RST;
        end
        else
        begin
            if (tick && !stall)
                ph <= ph + `RTCRD_PH_STEP;
            if (slot_end && (is_wr || st == M_RD))
                bitn <= (bitn == `RTCRD_ACK_BIT) ? `RTCRD_BIT_RST :
                    bitn + `RTCRD_BIT_STEP;
        end
    end

    // transmit shifter, same address pattern in both parts
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            txb <= 8'hff;
        else if (slot_end)
        begin
            if (st == M_ST1)
                txb <= id_byte(sel, (op == RTCRD_OP_CUR) ? `RTCRD_RW_READ :
                    `RTCRD_RW_WRITE);
            else if (st == M_ST2)
                txb <= id_byte(sel, `RTCRD_RW_READ);
            else if (st == M_DEVW && bitn == `RTCRD_ACK_BIT)
                txb <= addr[`RTCRD_AHI];
            else if (st == M_AHI && bitn == `RTCRD_ACK_BIT)
                txb <= addr[`RTCRD_ALO];
            else
                txb <= {txb[`RTCRD_MSB-1:0], 1'b1};
        end
    end

    // sampling of ack and read bits, nack report
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ackok <= 1'b0;
            rxb <= 8'h00;
            nack <= 1'b0;
        end
        else
        begin
            if (smp && is_wr && bitn == `RTCRD_ACK_BIT)
                ackok <= !sda_f;
            if (smp && st == M_RD && bitn != `RTCRD_ACK_BIT)
                rxb <= {rxb[`RTCRD_MSB-1:0], sda_f};
            nack <= slot_end && is_wr && bitn == `RTCRD_ACK_BIT && !ackok;
        end
    end

    // read data buffer
    rtcrd_fifo #(
        .W(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data({rxb[`RTCRD_MSB-1:0], sda_f}),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );
endmodule
